// ---- include/sarc_pkg.sv ----
// Package: register map, field layout, reset values, states and timing of the converter control
package sarc_pkg;
	localparam logic [7:0] SARC_ADDR_PAIR = 8'hba;
	localparam logic [7:0] SARC_ADDR_CHAN = 8'hbb;
	localparam logic [7:0] SARC_ADDR_CFG = 8'hbc;
	localparam logic [7:0] SARC_ADDR_CTRL = 8'hbd;
	localparam logic [7:0] SARC_ADDR_RESULT = 8'hbe;
	localparam logic [7:0] SARC_PAIR_RST = 8'h00;
	localparam logic [7:0] SARC_CHAN_RST = 8'h00;
	localparam logic [7:0] SARC_CFG_RST = 8'hf8;
	localparam logic [7:0] SARC_CTRL_RST = 8'h00;
	localparam logic [7:0] SARC_ZERO8 = 8'h00;
	localparam int SARC_CTRL_EN = 7;
	localparam int SARC_CTRL_TM = 6;
	localparam int SARC_CTRL_DONE = 5;
	localparam int SARC_CTRL_BUSY = 4;
	localparam int SARC_CTRL_CM_HI = 3;
	localparam int SARC_CTRL_CM_LO = 1;
	localparam int SARC_CFG_SC_HI = 7;
	localparam int SARC_CFG_SC_LO = 3;
	localparam int SARC_CFG_GN_HI = 1;
	localparam int SARC_CFG_GN_LO = 0;
	localparam int SARC_PAIR_W = 4;
	localparam int SARC_CHAN_W = 3;
	localparam logic [2:0] SARC_CM_SW = 3'h0;
	localparam logic [2:0] SARC_CM_TMR3 = 3'h1;
	localparam logic [2:0] SARC_CM_EXT = 3'h2;
	localparam logic [2:0] SARC_CM_TMR2 = 3'h3;
	localparam logic [1:0] SARC_TRACK_CLKS = 2'h3;
	localparam logic [3:0] SARC_CONV_CLKS = 4'ha;
	localparam logic [3:0] SARC_SAR_BITS = 4'h8;
	localparam logic [7:0] SARC_SAR_MSB = 8'h80;
	localparam logic [7:0] SARC_TWOS_FLIP = 8'h80;
	typedef enum logic [1:0] {SARC_IDLE, SARC_TRACK, SARC_CONV} sarc_state_type;
endpackage : sarc_pkg

// ---- include/sarc_ctl_if.sv ----
// Interface between the control top, the clock divider and the start selector
`timescale 1ns/10ps
interface sarc_ctl_if;
	logic [4:0] div_val;
	logic div_run;
	logic tick;
	logic [2:0] start_mode;
	logic sw_start;
	logic prim_start;
	logic ext_level;
	logic start_pulse;
	modport top (output div_val, output div_run, output start_mode, output sw_start,
		output prim_start, input tick, input ext_level, input start_pulse);
	modport div (input div_val, input div_run, output tick);
	modport start (input start_mode, input sw_start, input prim_start, output ext_level,
		output start_pulse);
endinterface : sarc_ctl_if

// ---- rtl/sarc_clkdiv.sv ----
// Conversion clock divider producing a one-cycle tick
`timescale 1ns/10ps
module sarc_clkdiv
	import sarc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	sarc_ctl_if.div ctl
);
	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} sarc_div_type;
	sarc_div_type st_r;
	sarc_div_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!ctl.div_run) begin
			st_nxt.cnt = 5'h00;
		end else if (st_r.cnt >= ctl.div_val) begin
			st_nxt.cnt = 5'h00;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 5'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ctl.tick = st_r.tick;
endmodule : sarc_clkdiv

// ---- rtl/sarc_start.sv ----
// Start-of-conversion source selection with external pin synchronisers
`timescale 1ns/10ps
module sarc_start
	import sarc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic dedicated_start_pin,
	input wire logic shared_start_pin,
	input wire logic dedicated_start_en,
	input wire logic shared_start_en,
	input wire logic timer3_ovf,
	input wire logic timer2_ovf,
	sarc_ctl_if.start ctl
);
	typedef struct packed {
		logic [1:0] ded_sync;
		logic [1:0] sh_sync;
		logic ext_prev;
		logic ext_level;
		logic start_pulse;
	} sarc_start_type;
	sarc_start_type st_r;
	sarc_start_type st_nxt;
	logic ext_sel;
	logic ext_rise;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ded_sync = {st_r.ded_sync[0], dedicated_start_pin};
		st_nxt.sh_sync = {st_r.sh_sync[0], shared_start_pin};
		ext_sel = 1'b0;
		if (dedicated_start_en) begin
			ext_sel = st_r.ded_sync[1];
		end else if (shared_start_en) begin
			ext_sel = st_r.sh_sync[1];
		end
		st_nxt.ext_prev = ext_sel;
		st_nxt.ext_level = ext_sel;
		ext_rise = ext_sel & ~st_r.ext_prev;
		case (ctl.start_mode)
			SARC_CM_SW: st_nxt.start_pulse = ctl.sw_start;
			SARC_CM_TMR3: st_nxt.start_pulse = timer3_ovf;
			SARC_CM_EXT: st_nxt.start_pulse = ext_rise;
			SARC_CM_TMR2: st_nxt.start_pulse = timer2_ovf;
			default: st_nxt.start_pulse = ctl.prim_start;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ctl.ext_level = st_r.ext_level;
	assign ctl.start_pulse = st_r.start_pulse;
endmodule : sarc_start

// ---- rtl/sarc_top.sv ----
// Successive-approximation converter control: registers, sequencing and result capture
//
// Operation
// - Subsystem runs only while enable bit is 1; otherwise in shutdown.
// - Conversion clock is system clock divided by divider setting plus one.
// - Three-bit start source picks one of five start events.
// - Start source 010 selects the external start signal.
// - Dedicated pin starts if enabled, otherwise shared pin if enabled.
// - Busy bit reads 1 during conversion, returns to 0 at completion.
// - Busy falling sets done flag and requests interrupt when enabled.
// - Each conversion end places the result in the readable result register.
// - Normal tracking mode tracks continuously except during conversion.
// - Low-power tracking mode tracks three conversion clocks after start.
// - Low-power with external start tracks while pin low, converts on rise.
// - Tracking is shut down while the chip is in standby or sleep.
// - Gain choices 0.5, 1, 2, 4; gain 0.5 after reset.
// - Channel select picks one of eight inputs for the converter.
// - Gain field 00, 01, 10, 11 means 0.5, 1, 2, 4.
// - Three-bit channel field values 000 to 111 select the inputs.
// - Pair bit set joins two adjacent inputs as a differential pair.
// - Differential channels deliver results in two's complement.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module sarc_top
	import sarc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic dedicated_start_pin,
	input wire logic shared_start_pin,
	input wire logic dedicated_start_en,
	input wire logic shared_start_en,
	input wire logic timer3_ovf,
	input wire logic timer2_ovf,
	input wire logic primary_busy_write,
	input wire logic chip_standby,
	input wire logic done_irq_enable,
	input wire logic sar_compare_hi,
	output logic converter_power_en,
	output logic track_en,
	output logic [7:0] sar_trial_code,
	output logic [2:0] mux_channel,
	output logic mux_differential,
	output logic [1:0] gain_select,
	output logic [3:0] pair_config,
	output logic done_irq
);
	typedef struct packed {
		sarc_state_type state;
		logic [3:0] cnt;
		logic [7:0] trial;
		logic [7:0] result;
		logic enable;
		logic low_power_track;
		logic done;
		logic [2:0] start_src;
		logic [4:0] clk_div;
		logic [1:0] gain;
		logic [2:0] chan;
		logic [3:0] pair;
		logic sw_start;
		logic prim_start;
		logic [7:0] rdata;
		logic track;
		logic irq;
		logic diff;
	} sarc_top_type;
	sarc_top_type st_r;
	sarc_top_type st_nxt;
	sarc_ctl_if ctl ();
	logic busy;
	logic diff_sel;
	logic ext_mode;
	logic done_set;
	logic [7:0] bit_mask;

	sarc_clkdiv u_clkdiv (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ctl(ctl.div)
	);

	sarc_start u_start (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.dedicated_start_pin(dedicated_start_pin),
		.shared_start_pin(shared_start_pin),
		.dedicated_start_en(dedicated_start_en),
		.shared_start_en(shared_start_en),
		.timer3_ovf(timer3_ovf),
		.timer2_ovf(timer2_ovf),
		.ctl(ctl.start)
	);

	assign ctl.div_val = st_r.clk_div;
	assign ctl.div_run = st_r.enable;
	assign ctl.start_mode = st_r.start_src;
	assign ctl.sw_start = st_r.sw_start;
	assign ctl.prim_start = st_r.prim_start;

	always_comb begin
		st_nxt = st_r;
		busy = (st_r.state != SARC_IDLE);
		ext_mode = (st_r.start_src == SARC_CM_EXT);
		diff_sel = st_r.pair[st_r.chan[2:1]];
		done_set = 1'b0;
		bit_mask = SARC_SAR_MSB >> (st_r.cnt[2:0]);
		st_nxt.sw_start = 1'b0;
		st_nxt.prim_start = primary_busy_write & st_r.enable;
		st_nxt.rdata = SARC_ZERO8;

		// Conversion sequencing
		case (st_r.state)
			SARC_IDLE: begin
				st_nxt.cnt = 4'h0;
				if (ctl.start_pulse && st_r.enable) begin
					if (st_r.low_power_track && !ext_mode) begin
						st_nxt.state = SARC_TRACK;
					end else begin
						st_nxt.state = SARC_CONV;
						st_nxt.trial = SARC_SAR_MSB;
					end
				end
			end
			SARC_TRACK: begin
				if (ctl.tick) begin
					if (st_r.cnt == {2'b00, SARC_TRACK_CLKS} - 4'h1) begin
						st_nxt.state = SARC_CONV;
						st_nxt.cnt = 4'h0;
						st_nxt.trial = SARC_SAR_MSB;
					end else begin
						st_nxt.cnt = st_r.cnt + 4'h1;
					end
				end
			end
			SARC_CONV: begin
				if (ctl.tick) begin
					if (st_r.cnt < SARC_SAR_BITS) begin
						if (!sar_compare_hi) begin
							st_nxt.trial = st_r.trial & ~bit_mask;
						end
						if (st_r.cnt < SARC_SAR_BITS - 4'h1) begin
							st_nxt.trial = (sar_compare_hi ? st_r.trial
								: (st_r.trial & ~bit_mask)) | (bit_mask >> 1);
						end
					end
					if (st_r.cnt == SARC_CONV_CLKS - 4'h1) begin
						st_nxt.state = SARC_IDLE;
						st_nxt.cnt = 4'h0;
						done_set = 1'b1;
						st_nxt.result = diff_sel ? (st_r.trial ^ SARC_TWOS_FLIP)
							: st_r.trial;
					end else begin
						st_nxt.cnt = st_r.cnt + 4'h1;
					end
				end
			end
			default: begin
				st_nxt.state = SARC_IDLE;
			end
		endcase

		// Register writes
		if (reg_wr) begin
			if (reg_addr == SARC_ADDR_PAIR) begin
				st_nxt.pair = reg_wdata[SARC_PAIR_W-1:0];
			end else if (reg_addr == SARC_ADDR_CHAN) begin
				st_nxt.chan = reg_wdata[SARC_CHAN_W-1:0];
			end else if (reg_addr == SARC_ADDR_CFG) begin
				st_nxt.clk_div = reg_wdata[SARC_CFG_SC_HI:SARC_CFG_SC_LO];
				st_nxt.gain = reg_wdata[SARC_CFG_GN_HI:SARC_CFG_GN_LO];
			end else if (reg_addr == SARC_ADDR_CTRL) begin
				st_nxt.enable = reg_wdata[SARC_CTRL_EN];
				st_nxt.low_power_track = reg_wdata[SARC_CTRL_TM];
				st_nxt.done = reg_wdata[SARC_CTRL_DONE];
				st_nxt.start_src = reg_wdata[SARC_CTRL_CM_HI:SARC_CTRL_CM_LO];
				st_nxt.sw_start = reg_wdata[SARC_CTRL_BUSY] & reg_wdata[SARC_CTRL_EN]
					& st_r.enable & !busy;
			end
		end

		// Hardware set wins over a software clear
		if (done_set) begin
			st_nxt.done = 1'b1;
		end

		// Shutdown aborts any conversion
		if (!st_nxt.enable) begin
			st_nxt.state = SARC_IDLE;
			st_nxt.cnt = 4'h0;
		end

		// Read data, valid the cycle after the strobe
		if (reg_rd) begin
			if (reg_addr == SARC_ADDR_PAIR) begin
				st_nxt.rdata = {4'h0, st_r.pair};
			end else if (reg_addr == SARC_ADDR_CHAN) begin
				st_nxt.rdata = {5'h00, st_r.chan};
			end else if (reg_addr == SARC_ADDR_CFG) begin
				st_nxt.rdata = {st_r.clk_div, 1'b0, st_r.gain};
			end else if (reg_addr == SARC_ADDR_CTRL) begin
				st_nxt.rdata = {st_r.enable, st_r.low_power_track, st_r.done,
					busy, st_r.start_src, 1'b0};
			end else if (reg_addr == SARC_ADDR_RESULT) begin
				st_nxt.rdata = st_r.result;
			end
		end

		// Track-and-hold control
		if (!st_r.enable || chip_standby) begin
			st_nxt.track = 1'b0;
		end else if (!st_r.low_power_track) begin
			st_nxt.track = (st_nxt.state != SARC_CONV);
		end else if (ext_mode) begin
			st_nxt.track = (st_nxt.state == SARC_IDLE) && !ctl.ext_level;
		end else begin
			st_nxt.track = (st_nxt.state == SARC_TRACK);
		end

		st_nxt.irq = st_nxt.done & done_irq_enable;
		st_nxt.diff = st_nxt.pair[st_nxt.chan[2:1]];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.state <= SARC_IDLE;
			st_r.enable <= SARC_CTRL_RST[SARC_CTRL_EN];
			st_r.low_power_track <= SARC_CTRL_RST[SARC_CTRL_TM];
			st_r.done <= SARC_CTRL_RST[SARC_CTRL_DONE];
			st_r.start_src <= SARC_CTRL_RST[SARC_CTRL_CM_HI:SARC_CTRL_CM_LO];
			st_r.clk_div <= SARC_CFG_RST[SARC_CFG_SC_HI:SARC_CFG_SC_LO];
			st_r.gain <= SARC_CFG_RST[SARC_CFG_GN_HI:SARC_CFG_GN_LO];
			st_r.chan <= SARC_CHAN_RST[SARC_CHAN_W-1:0];
			st_r.pair <= SARC_PAIR_RST[SARC_PAIR_W-1:0];
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign converter_power_en = st_r.enable;
	assign track_en = st_r.track;
	assign sar_trial_code = st_r.trial;
	assign mux_channel = st_r.chan;
	assign mux_differential = st_r.diff;
	assign gain_select = st_r.gain;
	assign pair_config = st_r.pair;
	assign done_irq = st_r.irq;
endmodule : sarc_top

// ---- tb/sarc_top_chk.sv ----
// Checker: port-level properties of the converter control
`timescale 1ns/10ps
module sarc_top_chk
	import sarc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic chip_standby,
	input wire logic done_irq_enable,
	input wire logic converter_power_en,
	input wire logic track_en,
	input wire logic [7:0] sar_trial_code,
	input wire logic [2:0] mux_channel,
	input wire logic mux_differential,
	input wire logic [1:0] gain_select,
	input wire logic [3:0] pair_config,
	input wire logic done_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence ctrl_wr;
		reg_wr && reg_addr == SARC_ADDR_CTRL;
	endsequence
	sequence sw_start;
		ctrl_wr ##0 (reg_wdata[7:1] == 7'h48 && converter_power_en);
	endsequence
	a_sw_start: assert property (sw_start |-> ##[1:4] (sar_trial_code == SARC_SAR_MSB && !track_en))
		else $error("software start did not begin a conversion");
	a_power_wr: assert property (ctrl_wr |=> converter_power_en == $past(reg_wdata[SARC_CTRL_EN]))
		else $error("power enable does not follow control write");
	a_shut_track: assert property (!converter_power_en ##1 !converter_power_en |-> !track_en)
		else $error("tracking while shut down");
	a_standby_track: assert property (chip_standby [*3] |-> !track_en)
		else $error("tracking during standby");
	a_irq_gate: assert property (done_irq |-> $past(done_irq_enable))
		else $error("done interrupt while disabled");
	a_diff_sel: assert property (mux_differential == pair_config[mux_channel[2:1]])
		else $error("differential flag does not match pair bit");
	a_gain_rst: assert property ($rose(rstn) |-> gain_select == 2'h0)
		else $error("gain not 0.5 after reset");
	a_gain_wr: assert property (reg_wr && reg_addr == SARC_ADDR_CFG |=> gain_select == $past(reg_wdata[1:0]))
		else $error("gain field not updated");
	a_chan_wr: assert property (reg_wr && reg_addr == SARC_ADDR_CHAN |=> mux_channel == $past(reg_wdata[2:0]))
		else $error("channel field not updated");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == SARC_ZERO8)
		else $error("read data outside read cycle");
endmodule : sarc_top_chk
bind sarc_top sarc_top_chk u_sarc_top_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .chip_standby, .done_irq_enable, .converter_power_en, .track_en,
	.sar_trial_code, .mux_channel, .mux_differential, .gain_select, .pair_config, .done_irq);

// ---- tb/sarc_top_tb.sv ----
// Testbench: register access, start sources and result capture of the converter control
`timescale 1ns/10ps
module sarc_top_tb;
	import sarc_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata, sar_trial_code, v;
	logic [4:0] trig = 5'h00;
	logic ded_en = 1'b1;
	logic sh_en = 1'b1;
	logic chip_standby = 1'b0;
	logic done_irq_enable = 1'b1;
	logic sar_compare_hi = 1'b1;
	logic converter_power_en, track_en, mux_differential, done_irq;
	logic [2:0] mux_channel;
	logic [1:0] gain_select;
	logic [3:0] pair_config;
	logic [7:0] ra[5] = '{SARC_ADDR_PAIR, SARC_ADDR_CHAN, SARC_ADDR_CFG, SARC_ADDR_CTRL, 8'h00};
	logic [7:0] rv[5] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00};
	int src[5] = '{7, 0, 2, 1, 3};
	int err_total = 0;
	int samples_checked = 0;
	int i, n;
	sarc_top u_sarc_top (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.dedicated_start_pin(trig[2]), .shared_start_pin(trig[4]), .dedicated_start_en(ded_en),
		.shared_start_en(sh_en), .timer3_ovf(trig[0]), .timer2_ovf(trig[1]),
		.primary_busy_write(trig[3]), .chip_standby, .done_irq_enable, .sar_compare_hi,
		.converter_power_en, .track_en, .sar_trial_code, .mux_channel, .mux_differential,
		.gain_select, .pair_config, .done_irq);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask : rd
	task automatic pulse(input int k);
		trig[k] <= 1'b1;
		@(posedge ref_clk);
		trig[k] <= 1'b0;
		@(posedge ref_clk);
	endtask : pulse
	task automatic conv(input logic [2:0] mode, input int s, input logic [7:0] exp);
		logic [7:0] c;
		int k;
		wr(SARC_ADDR_CTRL, {4'h8, mode, 1'b0});
		if (s > 4)
			wr(SARC_ADDR_CTRL, {4'h9, mode, 1'b0});
		else
			pulse(s);
		c = 8'h00;
		for (k = 0; k < 20 && c[SARC_CTRL_BUSY] !== 1'b1; k++) rd(SARC_ADDR_CTRL, c);
		chk("busy", c & 8'h30, 8'h10);
		for (k = 0; k < 40 && c[SARC_CTRL_DONE] !== 1'b1; k++) rd(SARC_ADDR_CTRL, c);
		chk("done", c & 8'h30, 8'h20);
		chk("irq", {7'h00, done_irq}, 8'h01);
		rd(SARC_ADDR_RESULT, c);
		chk("result", c, exp);
	endtask : conv
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		chk("gain rst", {6'h00, gain_select}, 8'h00);
		for (i = 0; i < 5; i++) begin
			rd(ra[i], v);
			chk("reset", v, rv[i]);
		end
		for (i = 0; i < 8; i++) begin
			wr(SARC_ADDR_CHAN, 8'hf8 | 8'(i));
			wr(SARC_ADDR_CFG, 8'h04 | 8'(i % 4));
			rd(SARC_ADDR_CHAN, v);
			chk("chan", v, 8'(i));
			chk("mux", {5'h00, mux_channel}, 8'(i));
			rd(SARC_ADDR_CFG, v);
			chk("cfg", v, 8'(i % 4));
			chk("gain", {6'h00, gain_select}, 8'(i % 4));
		end
		wr(SARC_ADDR_PAIR, 8'hf5);
		wr(8'hbf, 8'hff);
		rd(SARC_ADDR_PAIR, v);
		chk("pair", v, 8'h05);
		chk("diff", {7'h00, mux_differential}, 8'h00);
		rd(8'hbf, v);
		chk("unmapped", v, 8'h00);
		wr(SARC_ADDR_CTRL, 8'h80);
		chk("power", {7'h00, converter_power_en}, 8'h01);
		@(posedge ref_clk);
		chk("track", {7'h00, track_en}, 8'h01);
		chip_standby <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("standby", {7'h00, track_en}, 8'h00);
		chip_standby <= 1'b0;
		for (i = 0; i < 5; i++) conv(3'(i), src[i], 8'hff);
		wr(SARC_ADDR_CTRL, 8'h84);
		pulse(4);
		pulse(0);
		repeat (8) @(posedge ref_clk);
		rd(SARC_ADDR_CTRL, v);
		chk("no start", v, 8'h84);
		wr(SARC_ADDR_CFG, 8'h1b);
		wr(SARC_ADDR_CTRL, 8'h90);
		for (n = 0; n < 60 && sar_trial_code !== 8'hc0; n++) @(posedge ref_clk);
		for (n = 0; n < 60 && sar_trial_code !== 8'he0; n++) @(posedge ref_clk);
		chk("tick period", 8'(n), 8'h04);
		repeat (40) @(posedge ref_clk);
		wr(SARC_ADDR_CFG, 8'h03);
		wr(SARC_ADDR_PAIR, 8'h08);
		conv(3'h0, 7, 8'h7f);
		ded_en <= 1'b0;
		conv(3'h2, 4, 8'h7f);
		wr(SARC_ADDR_CTRL, 8'hd0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("lp track", {7'h00, track_en}, 8'h01);
		repeat (20) @(posedge ref_clk);
		rd(SARC_ADDR_RESULT, v);
		chk("lp result", v, 8'h7f);
		wr(SARC_ADDR_CTRL, 8'h00);
		chk("shutdown", {7'h00, converter_power_en}, 8'h00);
		wrap_up();
	end
endmodule : sarc_top_tb
